// >>> core/burst_core.sv
// Burst clock generator, state strobes and center-frequency register.
`timescale 1ns/1ps
module burst_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic power_up_detect_n_i,
  // Sequencer side
  input wire logic [6:0] state_i,
  input burst_pkg::burst_req_t req_i,
  input wire logic range_ok_i,
  input wire logic plugin_load_n_i,
  input wire logic bus_to_mreg_n_i,
  input burst_pkg::key_digit_t key_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Flags and clocks
  output logic count_match_flag_o,
  output logic ten_or_more_flag_o,
  output logic [3:0] count_o,
  output logic ninth_clock_n_o,
  output logic shared_clk_en_o,
  output logic mreg_clk_en_o,
  output logic plugin_clock_n_o,
  output logic readout_burst10_o,
  // Decoded outputs and control-register bits
  output logic [3:0] code_enable_n_o,
  output logic [15:0] dec1_n_o,
  output logic [15:0] dec2_n_o,
  output logic [15:0] dec3_n_o,
  output burst_pkg::instr_t instr_o,
  output logic low_digit_zero_n_o,
  output logic accum_out_enable_o,
  // Digit buses
  output logic [3:0] result_bus_o,
  output logic [3:0] transfer_bus_o,
  output logic [3:0] plugin_data_o
);
  import burst_pkg::*;

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  logic [3:0] code_w;
  logic [15:0] d1_w;
  logic [15:0] d2_w;
  logic [15:0] d3_w;
  instr_t instr_w;

  state_decoder u_dec (
    .state_i(state_i),
    .code_enable_n_o(code_w),
    .dec1_n_o(d1_w),
    .dec2_n_o(d2_w),
    .dec3_n_o(d3_w),
    .instr_o(instr_w)
  );

  // ----------------------------------------------------------------
  // Burst counter
  // ----------------------------------------------------------------
  function automatic logic [3:0] target(input burst_req_t r);
    if (!r.burst13_req_n) begin
      return CNT_THIRTEEN;
    end else if (!r.burst12_req_n) begin
      return CNT_TWELVE;
    end
    return CNT_TEN;
  endfunction

  logic any_req;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic match_reg;
  logic match_next;
  logic tom_reg;
  logic tom_next;
  logic ninth_reg;
  logic ninth_next;
  burst_state_t st_reg;
  burst_state_t st_next;

  always_comb begin
    any_req = !(req_i.burst10_req_n & req_i.burst12_req_n
      & req_i.burst13_req_n & req_i.jam10_req_n);
    cnt_next = cnt_reg;
    st_next = st_reg;
    unique case (st_reg)
      IDLE: begin
        cnt_next = CNT_RESET;
        if (any_req) begin
          st_next = COUNT;
          cnt_next = 4'h1;
        end
      end
      COUNT: begin
        if (!any_req) begin
          st_next = IDLE;
          cnt_next = CNT_RESET;
        end else if (cnt_reg == target(req_i)) begin
          st_next = DONE;
        end else begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      DONE: begin
        if (!any_req) begin
          st_next = IDLE;
          cnt_next = CNT_RESET;
        end
      end
      default: begin
        st_next = IDLE;
        cnt_next = CNT_RESET;
      end
    endcase
    match_next = any_req && (cnt_next == target(req_i));
    tom_next = any_req && (cnt_next >= CNT_TEN);
    ninth_next = !(any_req && cnt_next == CNT_NINE);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= IDLE;
      cnt_reg <= CNT_RESET;
      match_reg <= 1'b0;
      tom_reg <= 1'b0;
      ninth_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      match_reg <= match_next;
      tom_reg <= tom_next;
      ninth_reg <= ninth_next;
    end
  end

  // ----------------------------------------------------------------
  // Clock gates
  // ----------------------------------------------------------------
  logic shared_reg;
  logic shared_next;
  logic mreg_reg;
  logic mreg_next;
  logic pick_reg;
  logic pick_next;
  logic ro10_reg;
  logic ro10_next;

  always_comb begin
    shared_next = !req_i.burst10_req_n && any_req && !(cnt_next >= CNT_TEN);
    mreg_next = !bus_to_mreg_n_i && any_req && !match_next;
    pick_next = !(!plugin_load_n_i && shared_next);
    ro10_next = shared_next;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shared_reg <= 1'b0;
      mreg_reg <= 1'b0;
      pick_reg <= 1'b1;
      ro10_reg <= 1'b0;
    end else begin
      shared_reg <= shared_next;
      mreg_reg <= mreg_next;
      pick_reg <= pick_next;
      ro10_reg <= ro10_next;
    end
  end

  // ----------------------------------------------------------------
  // Center-frequency register
  // ----------------------------------------------------------------
  logic [DIGIT_W-1:0] cf_reg [DIGITS];
  logic [DIGIT_W-1:0] cf_next [DIGITS];
  logic [3:0] rbus_reg;
  logic [3:0] rbus_next;
  logic [3:0] tbus_reg;
  logic [3:0] tbus_next;
  logic [3:0] pdat_reg;
  logic [3:0] pdat_next;
  logic load_ok;
  logic shift_en;

  always_comb begin
    load_ok = instr_w.keys_to_bus && instr_w.bus_to_center_reg && range_ok_i;
    shift_en = shared_reg;
    cf_next = cf_reg;
    rbus_next = DIGIT_ZERO;
    tbus_next = DIGIT_ZERO;
    if (shift_en) begin
      for (int i = 0; i < DIGITS - 1; i++) begin
        cf_next[i] = cf_reg[i + 1];
      end
      if (load_ok && !instr_w.center_to_result_bus) begin
        cf_next[DIGITS - 1] = key_i;
      end else begin
        cf_next[DIGITS - 1] = cf_reg[0];
      end
      if (instr_w.center_to_result_bus) begin
        rbus_next = cf_reg[0];
      end
      if (instr_w.center_to_transfer_bus) begin
        tbus_next = cf_reg[0];
      end
    end
    pdat_next = plugin_load_n_i ? DIGIT_ZERO : key_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !power_up_detect_n_i) begin
      for (int i = 0; i < DIGITS; i++) begin
        cf_reg[i] <= DIGIT_ZERO;
      end
      rbus_reg <= DIGIT_ZERO;
      tbus_reg <= DIGIT_ZERO;
      pdat_reg <= DIGIT_ZERO;
    end else begin
      cf_reg <= cf_next;
      rbus_reg <= rbus_next;
      tbus_reg <= tbus_next;
      pdat_reg <= pdat_next;
    end
  end

  // ----------------------------------------------------------------
  // Decoded outputs, registered
  // ----------------------------------------------------------------
  logic [3:0] code_reg;
  logic [15:0] d1_reg;
  logic [15:0] d2_reg;
  logic [15:0] d3_reg;
  instr_t instr_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_reg <= 4'hF;
      d1_reg <= 16'hFFFF;
      d2_reg <= 16'hFFFF;
      d3_reg <= 16'hFFFF;
      instr_reg <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    end else begin
      code_reg <= code_w;
      d1_reg <= d1_w;
      d2_reg <= d2_w;
      d3_reg <= d3_w;
      instr_reg <= instr_w;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  logic [2:0] ctl_reg;
  logic [2:0] ctl_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic req_now;

  always_comb begin
    req_now = cyc_i && stb_i && !ack_reg;
    ack_next = req_now;
    ctl_next = ctl_reg;
    rd_next = 32'h0000_0000;
    if (req_now && we_i && adr_i == ADR_CONTROL && sel_i[0]) begin
      ctl_next = dat_i[2:0];
    end
    if (req_now && !we_i) begin
      unique case (adr_i)
        ADR_CONTROL: rd_next = {29'h0, ctl_reg};
        ADR_STATUS: rd_next = {17'h0, st_reg, tom_reg, match_reg, cnt_reg, state_i};
        ADR_CENTER_LO: rd_next = {cf_reg[7], cf_reg[6], cf_reg[5], cf_reg[4],
          cf_reg[3], cf_reg[2], cf_reg[1], cf_reg[0]};
        ADR_CENTER_HI: rd_next = {24'h0, cf_reg[9], cf_reg[8]};
        default: rd_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_reg <= CONTROL_RESET;
      ack_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
    end else begin
      ctl_reg <= ctl_next;
      ack_reg <= ack_next;
      rd_reg <= rd_next;
    end
  end

  // ----------------------------------------------------------------
  // Output assignments
  // ----------------------------------------------------------------
  assign count_match_flag_o = match_reg;
  assign ten_or_more_flag_o = tom_reg;
  assign count_o = cnt_reg;
  assign ninth_clock_n_o = ninth_reg;
  assign shared_clk_en_o = shared_reg;
  assign mreg_clk_en_o = mreg_reg;
  assign plugin_clock_n_o = pick_reg;
  assign readout_burst10_o = ro10_reg;
  assign code_enable_n_o = code_reg;
  assign dec1_n_o = d1_reg;
  assign dec2_n_o = d2_reg;
  assign dec3_n_o = d3_reg;
  assign instr_o = instr_reg;
  assign low_digit_zero_n_o = !ctl_reg[CTL_LOW_ZERO_BIT];
  assign accum_out_enable_o = ctl_reg[CTL_ACCUM_EN_BIT];
  assign result_bus_o = rbus_reg;
  assign transfer_bus_o = tbus_reg;
  assign plugin_data_o = pdat_reg;
  assign dat_o = rd_reg;
  assign ack_o = ack_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_req_start;
    !any_req ##1 any_req;
  endsequence

  a_idle_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
    !any_req |=> cnt_reg == CNT_RESET) else $error("counter not cleared");
  a_count_advance: assert property (@(posedge clk_i) disable iff (rst_i)
    s_req_start |=> cnt_reg == 4'h1) else $error("counter did not start");
  a_match_twelve: assert property (@(posedge clk_i) disable iff (rst_i)
    (match_reg && !req_i.burst12_req_n && req_i.burst13_req_n && $stable(req_i))
    |-> cnt_reg == CNT_TWELVE) else $error("match not at twelve");
  a_ten_or_more: assert property (@(posedge clk_i) disable iff (rst_i)
    (cnt_reg >= CNT_TEN && st_reg != IDLE && $past(any_req)) |-> tom_reg)
    else $error("ten flag low");
  a_ninth_low: assert property (@(posedge clk_i) disable iff (rst_i)
    !ninth_reg |-> cnt_reg == CNT_NINE) else $error("ninth at wrong count");
  a_code_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot(~code_w)) else $error("code enable not one-hot");
  a_dec_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
    state_i[5:4] == 2'b01 |-> $onehot(~d1_w) && !d1_w[state_i[3:0]])
    else $error("decoder output wrong");
  a_point_state: assert property (@(posedge clk_i) disable iff (rst_i)
    !instr_w.set_center_point_n |-> state_i[5:0] == 6'h25 && instr_w.keys_to_bus)
    else $error("set point outside 2/5");
  a_shared_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    tom_reg |-> !shared_reg) else $error("shared clock past ten");
  a_power_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !power_up_detect_n_i |=> cf_reg[0] == DIGIT_ZERO)
    else $error("register not held");
endmodule

// >>> core/burst_pkg.sv
// Package with constants and carriers for the burst clock and center register block.
package burst_pkg;

  // ----------------------------------------------------------------
  // Counter targets and widths
  // ----------------------------------------------------------------
  localparam logic [3:0] CNT_NINE = 4'h9;
  localparam logic [3:0] CNT_TEN = 4'hA;
  localparam logic [3:0] CNT_TWELVE = 4'hC;
  localparam logic [3:0] CNT_THIRTEEN = 4'hD;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam int DIGITS = 10;
  localparam int DIGIT_W = 4;
  localparam logic [3:0] DIGIT_ZERO = 4'h0;

  // ----------------------------------------------------------------
  // Wishbone register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADR_CONTROL = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam logic [3:0] ADR_CENTER_LO = 4'h8;
  localparam logic [3:0] ADR_CENTER_HI = 4'hC;
  localparam int CTL_LOW_ZERO_BIT = 0;
  localparam int CTL_ACCUM_EN_BIT = 1;
  localparam int CTL_REMOTE_BIT = 2;
  localparam logic [2:0] CONTROL_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic burst10_req_n;
    logic burst12_req_n;
    logic burst13_req_n;
    logic jam10_req_n;
  } burst_req_t;

  typedef struct packed {
    logic unit_select_instr_n;
    logic clear_flag3_instr_n;
    logic set_flag2_instr_n;
    logic set_flag3_n;
    logic set_center_point_n;
    logic bus_to_center_reg;
    logic keys_to_bus;
    logic center_to_result_bus;
    logic center_to_transfer_bus;
  } instr_t;

  typedef struct packed {
    logic key_digit_bit8;
    logic key_digit_bit4;
    logic key_digit_bit2;
    logic key_digit_bit1;
  } key_digit_t;

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    COUNT = 2'b01,
    DONE = 2'b11
  } burst_state_t;

endpackage

// >>> core/state_decoder.sv
// Decoder that turns the seven-bit machine state into instruction strobes.
`timescale 1ns/1ps
module state_decoder (
  // State input
  input wire logic [6:0] state_i,
  // Decoded enables and instructions
  output logic [3:0] code_enable_n_o,
  output logic [15:0] dec1_n_o,
  output logic [15:0] dec2_n_o,
  output logic [15:0] dec3_n_o,
  output burst_pkg::instr_t instr_o
);
  import burst_pkg::*;

  function automatic logic [15:0] one_low(input logic en, input logic [3:0] idx);
    logic [15:0] v;
    v = 16'hFFFF;
    if (en) begin
      v[idx] = 1'b0;
    end
    return v;
  endfunction

  logic [3:0] code_n;
  logic [3:0] low4;
  logic [15:0] d1;
  logic [15:0] d2;
  logic [15:0] d3;

  always_comb begin
    low4 = state_i[3:0];
    code_n = 4'hF;
    code_n[state_i[5:4]] = 1'b0;
    d1 = one_low(!code_n[1], low4);
    d2 = one_low(!code_n[2], low4);
    d3 = one_low(!code_n[3], low4);
    code_enable_n_o = code_n;
    dec1_n_o = d1;
    dec2_n_o = d2;
    dec3_n_o = d3;
    instr_o.unit_select_instr_n = d1[6];
    instr_o.clear_flag3_instr_n = d1[6];
    instr_o.set_flag2_instr_n = d1[6];
    instr_o.set_center_point_n = d2[5];
    instr_o.center_to_result_bus = !(d1[15] & d1[14] & d2[0] & d2[1]);
    instr_o.bus_to_center_reg = !d2[5] | instr_o.center_to_result_bus;
    instr_o.keys_to_bus = !(d2[5] & d1[4] & d1[13] & d1[12] & d1[11]);
    instr_o.set_flag3_n = d1[13] & d1[12] & d1[11] & d1[0];
    instr_o.center_to_transfer_bus = !d3[0];
  end
endmodule

// >>> testbench/seq_model.sv
// Sequencer model that issues burst requests and drops them on completion, or three cycles later with slow_i set.
`timescale 1ns/1ps
module seq_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench commands
  input wire logic go_i,
  input wire logic [1:0] kind_i,
  input wire logic slow_i,
  output logic busy_o,
  // Block side
  input wire logic count_match_flag_i,
  input wire logic ten_or_more_flag_i,
  output burst_pkg::burst_req_t req_o
);
  import burst_pkg::*;
  logic [1:0] wait_reg;
  // ----------------------------------------------------------------
  // Request issue and release
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      req_o <= '1;
      busy_o <= 1'b0;
      wait_reg <= 2'h0;
    end else if (go_i && !busy_o) begin
      req_o <= burst_req_t'(~(4'h8 >> kind_i));
      busy_o <= 1'b1;
      wait_reg <= slow_i ? 2'h3 : 2'h0;
    end else if (busy_o && count_match_flag_i && ten_or_more_flag_i) begin
      if (wait_reg == 2'h0) begin
        req_o <= '1;
        busy_o <= 1'b0;
      end else begin
        wait_reg <= wait_reg - 2'h1;
      end
    end
  end
endmodule

// >>> testbench/testbench.sv
// Self-checking testbench for the burst clock and center register block.
`timescale 1ns/1ps
module testbench;
  import burst_pkg::*;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH at %0t: got %h exp %h", $time, a, b); end end
  typedef struct packed {logic [3:0] top; logic [3:0] shr;} burst_exp_t;
  typedef struct packed {
    logic [3:0] en;
    logic [15:0] d1;
    logic [15:0] d2;
    logic [15:0] d3;
    instr_t ins;
  } dec_exp_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic power_up_detect_n_i = 1'b1;
  logic [6:0] state_i = '0;
  logic range_ok_i = 1'b0;
  logic plugin_load_n_i = 1'b1;
  logic bus_to_mreg_n_i = 1'b1;
  key_digit_t key_i = '0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] adr_i = '0;
  logic [3:0] sel_i = '0;
  logic [31:0] dat_i = '0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [1:0] kind = '0;
  burst_req_t req_i;
  logic [31:0] dat_o;
  logic ack_o, count_match_flag_o, ten_or_more_flag_o, ninth_clock_n_o, shared_clk_en_o, busy;
  logic [3:0] count_o, code_enable_n_o, plugin_data_o, result_bus_o, transfer_bus_o;
  logic mreg_clk_en_o, plugin_clock_n_o, readout_burst10_o;
  logic [3:0] nm = '0;
  logic [3:0] nr = '0;
  logic [3:0] nt = '0;
  logic [3:0] dig = '0;
  logic [15:0] dec1_n_o, dec2_n_o, dec3_n_o;
  instr_t instr_o;
  logic low_digit_zero_n_o, accum_out_enable_o;
  int err_total = 0;
  int n_checks = 0;
  burst_exp_t bq[$];
  dec_exp_t dq[$];
  dec_exp_t de;
  logic [31:0] rq[$];
  logic [31:0] rd;
  logic [15:0] lf = 16'h12FA;
  logic [3:0] mx = '0;
  logic [3:0] nn = '0;
  logic [3:0] ns = '0;

  burst_core uut (.clk_i, .rst_i, .power_up_detect_n_i, .state_i, .req_i, .range_ok_i,
    .plugin_load_n_i, .bus_to_mreg_n_i, .key_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .count_match_flag_o, .ten_or_more_flag_o, .count_o, .ninth_clock_n_o,
    .shared_clk_en_o, .mreg_clk_en_o, .plugin_clock_n_o, .readout_burst10_o,
    .code_enable_n_o, .dec1_n_o, .dec2_n_o, .dec3_n_o, .instr_o, .low_digit_zero_n_o,
    .accum_out_enable_o, .result_bus_o, .transfer_bus_o, .plugin_data_o);
  seq_model partner (.clk_i, .rst_i, .go_i(go), .kind_i(kind), .slow_i(slow), .busy_o(busy),
    .count_match_flag_i(count_match_flag_o), .ten_or_more_flag_i(ten_or_more_flag_o),
    .req_o(req_i));

  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic dec_exp_t dec_ref(input logic [6:0] s);
    dec_exp_t e;
    e.en = ~(4'h1 << s[5:4]);
    e.d1 = (s[5:4] == 2'h1) ? ~(16'h1 << s[3:0]) : 16'hFFFF;
    e.d2 = (s[5:4] == 2'h2) ? ~(16'h1 << s[3:0]) : 16'hFFFF;
    e.d3 = (s[5:4] == 2'h3) ? ~(16'h1 << s[3:0]) : 16'hFFFF;
    case (s[5:0])
      6'h16: e.ins = 9'h030;
      6'h25: e.ins = 9'h1EC;
      6'h1F, 6'h1E, 6'h20, 6'h21: e.ins = 9'h1FA;
      6'h14: e.ins = 9'h1F4;
      6'h1D, 6'h1C, 6'h1B: e.ins = 9'h1D4;
      6'h10: e.ins = 9'h1D0;
      6'h30: e.ins = 9'h1F1;
      default: e.ins = 9'h1F0;
    endcase
    return e;
  endfunction
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [31:0] ex);
    int n;
    n = 0;
    @(posedge clk_i);
    if (!w) rq.push_back(ex);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin err_total++; close_out(); end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic burst(input logic [1:0] k, input logic s);
    int n;
    n = 0;
    @(posedge clk_i);
    bq.push_back({k == 2'h2 ? CNT_THIRTEEN : k == 2'h1 ? CNT_TWELVE : CNT_TEN,
                  k == 2'h0 ? CNT_NINE : k == 2'h3 ? 4'hF : 4'h0});
    go <= 1'b1;
    kind <= k;
    slow <= s;
    lf = lfsr_next(lf);
    bus_to_mreg_n_i <= lf[0];
    @(posedge clk_i);
    go <= 1'b0;
    do begin @(posedge clk_i); n++; end while (busy === 1'b1 && n < 60);
    if (n >= 60) begin err_total++; close_out(); end
  endtask
  // ----------------------------------------------------------------
  // Output monitors
  // ----------------------------------------------------------------
  always begin
    @(posedge clk_i);
    #1;
    if (!rst_i) begin
      `CHK(ten_or_more_flag_o, count_o >= CNT_TEN)
      `CHK(count_match_flag_o, bq.size() != 0 && count_o == bq[0].top)
      `CHK(readout_burst10_o, shared_clk_en_o)
      `CHK(plugin_clock_n_o, !(shared_clk_en_o && !plugin_load_n_i))
      if (count_o !== CNT_RESET) begin
        `CHK(bq.size() != 0, 1'b1)
        mx = count_o;
        nn += {3'h0, !ninth_clock_n_o};
        ns += {3'h0, shared_clk_en_o};
        nm += {3'h0, mreg_clk_en_o};
        nr += {3'h0, result_bus_o == dig && dig != 4'h0};
        nt += {3'h0, transfer_bus_o == dig && dig != 4'h0};
      end else if (mx !== CNT_RESET) begin
        `CHK(nm, bus_to_mreg_n_i ? 4'h0 : bq[0].top - 4'h1)
        `CHK(nr, instr_o.center_to_result_bus ? ns : 4'h0)
        `CHK(nt, instr_o.center_to_transfer_bus ? ns : 4'h0)
        `CHK(mx, bq[0].top)
        `CHK(nn, 4'h1)
        if (bq[0].shr != 4'hF) `CHK(ns, bq[0].shr)
        void'(bq.pop_front());
        mx = '0;
        nn = '0;
        ns = '0;
        nm = '0;
        nr = '0;
        nt = '0;
      end
    end
    if (dq.size() != 0) begin
      de = dq.pop_front();
      `CHK({code_enable_n_o, dec1_n_o, dec2_n_o, dec3_n_o, instr_o}, de)
    end
  end
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && rq.size() != 0) begin
      rd = rq.pop_front();
      `CHK(dat_o, rd)
    end
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    close_out();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [6:0] prev;
    logic [3:0] d;
    repeat (15) @(posedge clk_i);
    @(negedge clk_i);
    `CHK({count_o, count_match_flag_o, ten_or_more_flag_o, ninth_clock_n_o}, 7'h01)
    @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 65; i++) begin
      @(posedge clk_i);
      if (i > 0) dq.push_back(dec_ref(prev));
      lf = lfsr_next(lf);
      prev = {lf[0], i[5:0]};
      state_i <= prev;
    end
    for (int k = 0; k < 8; k++) burst(k[1:0], k[2]);
    for (int v = 0; v < 8; v++) begin
      lf = lfsr_next(lf);
      wb(1'b1, ADR_CONTROL, {lf, 13'h0, v[2:0]}, 4'hF, '0);
      @(negedge clk_i);
      `CHK({low_digit_zero_n_o, accum_out_enable_o}, {~v[0], v[1]})
      wb(1'b0, ADR_CONTROL, '0, 4'hF, {29'h0, v[2:0]});
    end
    wb(1'b1, ADR_CONTROL, '0, 4'hE, '0);
    wb(1'b1, 4'h6, '0, 4'hF, '0);
    wb(1'b0, 4'h2, '0, 4'hF, '0);
    wb(1'b0, ADR_CONTROL, '0, 4'hF, 32'h7);
    lf = lfsr_next(lf);
    d = 4'h1 + {1'b0, lf[2:0]};
    dig = d;
    @(posedge clk_i);
    state_i <= 7'h25;
    key_i <= key_digit_t'(d);
    range_ok_i <= 1'b1;
    plugin_load_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    `CHK(plugin_data_o, d)
    burst(2'h0, 1'b0);
    burst(2'h0, 1'b1);
    wb(1'b0, ADR_CENTER_LO, '0, 4'hF, {8{d}});
    wb(1'b0, ADR_CENTER_HI, '0, 4'hF, {24'h0, d, d});
    @(posedge clk_i);
    key_i <= key_digit_t'(d + 4'h1);
    range_ok_i <= 1'b0;
    burst(2'h0, 1'b0);
    wb(1'b0, ADR_CENTER_LO, '0, 4'hF, {8{d}});
    @(posedge clk_i);
    state_i <= 7'h1F;
    repeat (2) @(posedge clk_i);
    burst(2'h0, 1'b0);
    wb(1'b0, ADR_CENTER_LO, '0, 4'hF, {8{d}});
    @(posedge clk_i);
    state_i <= 7'h30;
    repeat (2) @(posedge clk_i);
    burst(2'h0, 1'b0);
    wb(1'b0, ADR_CENTER_LO, '0, 4'hF, {8{d}});
    @(posedge clk_i);
    power_up_detect_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    power_up_detect_n_i <= 1'b1;
    wb(1'b0, ADR_CENTER_LO, '0, 4'hF, '0);
    wb(1'b0, ADR_CENTER_HI, '0, 4'hF, '0);
    repeat (2) @(posedge clk_i);
    close_out();
  end
endmodule
